/* File: rmeirq_pkg.sv */
// Purpose: constants and types for the remap error record / remap table base register bank
// Assumes: APB with 32-bit data, byte addresses, 64-bit registers split into two words
// Notes: one package, used by rmeirq_regs and test_rmeirq_regs
// Operation
// - detail code valid only while flag set
// - detail code zero means no cause
// - code one on invalid tail pointer
// - code two on descriptor fetch error
// - code three on invalid descriptor type
// - code four on reserved field violation
// - code five: 128-bit width in scalable mode
// - code five: 256-bit without scalable or abort
// - code six: 256-bit width, tail bit4 set
// - code seven on invalid root table mode
// - table base in bits 63:12, 4KB aligned
// - base bits above host width ignored
// - settings used only after set-pointer command
// - mode clear: destination bits 15:8 only
// - mode set: full 32-bit destination
// - no capability: mode bit reads zero
// - size field gives 2^(X+1) entries
// - no remap support: register reads zero
// - error record at offset 0B0h
package rmeirq_pkg;
    // register byte offsets (low word, high word)
    localparam logic [7:0] ERR_REC_LO = 8'hB0;
    localparam logic [7:0] ERR_REC_HI = 8'hB4;
    localparam logic [7:0] TBL_BASE_LO = 8'hB8;
    localparam logic [7:0] TBL_BASE_HI = 8'hBC;
    localparam logic [7:0] CTRL_OFS = 8'hE0;
    // table base field positions in the low word
    localparam int BASE_LSB = 12;
    localparam int EDM_BIT = 11;
    localparam int SIZE_MSB = 3;
    // control register bit positions
    localparam int CTRL_SET_PTR = 0;
    // queue error detail codes
    localparam logic [3:0] QE_NONE = 4'h0;
    localparam logic [3:0] QE_TAIL = 4'h1;
    localparam logic [3:0] QE_FETCH = 4'h2;
    localparam logic [3:0] QE_TYPE = 4'h3;
    localparam logic [3:0] QE_RSVD = 4'h4;
    localparam logic [3:0] QE_WIDTH = 4'h5;
    localparam logic [3:0] QE_ALIGN = 4'h6;
    localparam logic [3:0] QE_TTM = 4'h7;
    // scalable root table mode encoding
    localparam logic [1:0] TM_SCALABLE = 2'h1;
    // reset values
    localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;
    // queue error event bundle raised by the invalidation engine
    typedef struct packed {
        logic tail_bad;
        logic fetch_err;
        logic type_bad;
        logic rsvd_bad;
        logic width_256;
        logic tail_bit4;
        logic ttm_bad;
    } rmeirq_qevt_type;
    // capability straps
    typedef struct packed {
        logic remap_supported;
        logic extended_dest_capability;
        logic scalable_translation_supported;
        logic abort_dma_supported;
    } rmeirq_cap_type;
endpackage

/* File: rmeirq_regs.sv */
// Purpose: register bank for queue error detail and remap table base
// Assumes: APB slave, zero wait states, caps stable
// Notes: active table settings latch on the set-table-pointer strobe
`timescale 1ns/1ps
module rmeirq_regs #(
    parameter int HOST_ADDRESS_WIDTH = 48
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rmeirq_pkg::rmeirq_cap_type caps,
    input wire logic [1:0] translation_table_mode,
    input wire rmeirq_pkg::rmeirq_qevt_type qevt,
    input wire logic qevt_valid,
    input wire logic queue_error_flag,
    input wire logic remap_active_status,
    input wire logic [31:0] entry_dest_id,
    output logic [63:0] act_table_base,
    output logic act_extended_dest_mode_enable,
    output logic [3:0] act_size,
    output logic [16:0] act_entry_count,
    output logic [31:0] dest_id_used,
    output logic set_ptr_done
);
    //////////////////////////////////////////////////////////////////////////
    // state
    logic [63:0] base_ff; // programmed register value
    logic [63:0] nxt_base;
    logic [3:0] detail_ff; // queue error detail code
    logic [3:0] nxt_detail;
    logic [63:0] act_base_ff; // settings in use by the remap logic
    logic act_edm_ff;
    logic [3:0] act_size_ff;
    logic [16:0] act_cnt_ff;
    logic [31:0] dest_ff;
    logic done_ff;
    logic [31:0] rdata_ff;
    logic err_ff;
    logic rdy_ff;

    //////////////////////////////////////////////////////////////////////////
    // helpers
    // mask of implemented base bits: 63:12 below host width
    function automatic logic [63:0] base_mask(input int host_address_width);
        logic [63:0] m;
        m = '0;
        for (int i = rmeirq_pkg::BASE_LSB; i < 64; i++) begin
            if (i < host_address_width) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction
    localparam logic [63:0] BMASK = base_mask(HOST_ADDRESS_WIDTH);

    //////////////////////////////////////////////////////////////////////////
    // decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    // setup phase of a read: the answer is formed here so it stands with pready
    wire setup_rd = psel && !penable && !pwrite;
    wire hit_elo = paddr == rmeirq_pkg::ERR_REC_LO;
    wire hit_ehi = paddr == rmeirq_pkg::ERR_REC_HI;
    wire hit_blo = paddr == rmeirq_pkg::TBL_BASE_LO;
    wire hit_bhi = paddr == rmeirq_pkg::TBL_BASE_HI;
    wire hit_ctl = paddr == rmeirq_pkg::CTRL_OFS;
    wire mapped = hit_elo | hit_ehi | hit_blo | hit_bhi | hit_ctl;
    wire [31:0] bmask_word = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // writable bits of the low word: base, mode enable (if capable), size
    // mode bit gated by capability
    wire [31:0] lo_wmask = BMASK[31:0]
        | {20'h0_0000, caps.extended_dest_capability, 7'h00, 4'hF};
    wire wr_ok = caps.remap_supported;
    // upper bits beyond host width masked; bits 10:4 never stored
    wire [31:0] lo_keep = lo_wmask & bmask_word;
    wire [31:0] hi_keep = BMASK[63:32] & bmask_word;
    always_comb begin
        nxt_base = base_ff;
        if (wr && wr_ok && hit_blo) begin
            nxt_base[31:0] = (base_ff[31:0] & ~lo_keep) | (pwdata & lo_keep);
        end
        if (wr && wr_ok && hit_bhi) begin
            nxt_base[63:32] = (base_ff[63:32] & ~hi_keep) | (pwdata & hi_keep);
        end
    end
    // set-table-pointer command strobe
    wire set_ptr = wr && hit_ctl && pstrb[0] && pwdata[rmeirq_pkg::CTRL_SET_PTR] && wr_ok;

    //////////////////////////////////////////////////////////////////////////
    // queue error detail encoding, in the priority order of the checks
    // 128-bit width while scalable is a width fault
    wire w128_bad = !qevt.width_256 && (translation_table_mode == rmeirq_pkg::TM_SCALABLE);
    // 256-bit width with neither capability is a width fault
    wire w256_bad = qevt.width_256 && !caps.scalable_translation_supported
        && !caps.abort_dma_supported;
    // 256-bit width with tail bit 4 set
    wire align_bad = qevt.width_256 && qevt.tail_bit4;
    logic [3:0] code;
    always_comb begin
        // zero when no cause is known
        code = rmeirq_pkg::QE_NONE;
        if (qevt.tail_bad) begin
            code = rmeirq_pkg::QE_TAIL;
        end else if (w128_bad || w256_bad) begin
            code = rmeirq_pkg::QE_WIDTH;
        end else if (align_bad) begin
            code = rmeirq_pkg::QE_ALIGN;
        end else if (qevt.ttm_bad) begin
            code = rmeirq_pkg::QE_TTM;
        end else if (qevt.fetch_err) begin
            code = rmeirq_pkg::QE_FETCH;
        end else if (qevt.type_bad) begin
            code = rmeirq_pkg::QE_TYPE;
        end else if (qevt.rsvd_bad) begin
            code = rmeirq_pkg::QE_RSVD;
        end else begin
            code = rmeirq_pkg::QE_NONE;
        end
    end
    // capture only while the flag is not yet set, so the first cause stays
    always_comb begin
        nxt_detail = detail_ff;
        if (qevt_valid && !queue_error_flag) begin
            nxt_detail = code;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux
    // reads look at next-state values, so a write landing on the setup edge
    // of a read queued right behind it is already visible to that read
    // error record at 0B0h; base reads zero without support
    wire [31:0] rd_mux =
        hit_elo ? {28'h000_0000, nxt_detail} :
        hit_blo ? (wr_ok ? nxt_base[31:0] : 32'h0000_0000) :
        hit_bhi ? (wr_ok ? nxt_base[63:32] : 32'h0000_0000) :
        32'h0000_0000;
    // destination id interpretation
    // only bits 15:8 when mode clear; full id when set
    wire [31:0] dest_sel = act_edm_ff ? entry_dest_id : {16'h0000, entry_dest_id[15:8], 8'h00};
    wire [16:0] cnt_calc = 17'(17'h0_0001 << (base_ff[rmeirq_pkg::SIZE_MSB:0] + 5'h01));

    //////////////////////////////////////////////////////////////////////////
    // registers
    // bank state and bus answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            base_ff <= rmeirq_pkg::BASE_RST;
            detail_ff <= rmeirq_pkg::QE_NONE;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            base_ff <= nxt_base;
            detail_ff <= nxt_detail;
            rdata_ff <= setup_rd ? rd_mux : 32'h0000_0000;
            err_ff <= psel && !penable && !mapped;
            rdy_ff <= psel && !penable;
        end
    end
    // active table settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            act_base_ff <= rmeirq_pkg::BASE_RST;
            act_edm_ff <= 1'b0;
            act_size_ff <= 4'h0;
            act_cnt_ff <= 17'h0_0002;
            done_ff <= 1'b0;
            dest_ff <= 32'h0000_0000;
        end else begin
            if (set_ptr) begin
                act_base_ff <= base_ff & BMASK;
                act_edm_ff <= base_ff[rmeirq_pkg::EDM_BIT];
                act_size_ff <= base_ff[rmeirq_pkg::SIZE_MSB:0];
                act_cnt_ff <= cnt_calc;
            end
            done_ff <= set_ptr;
            dest_ff <= dest_sel;
        end
    end

    // bus outputs: no wait state, answer stands through the access phase
    assign prdata = rdata_ff;
    assign pready = rdy_ff;
    assign pslverr = err_ff;
    assign act_table_base = act_base_ff;
    assign act_extended_dest_mode_enable = act_edm_ff;
    assign act_size = act_size_ff;
    assign act_entry_count = act_cnt_ff;
    assign dest_id_used = dest_ff;
    assign set_ptr_done = done_ff;

    //////////////////////////////////////////////////////////////////////////
    // assertions
    // active base only changes after a set-pointer command
    property p_act_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !set_ptr |=> $stable(act_base_ff);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("active base moved");
    // command copies base one edge later
    property p_act_load;
        @(posedge clk_sys) disable iff (!rst_n)
        set_ptr |=> act_base_ff == ($past(base_ff) & BMASK) && set_ptr_done;
    endproperty
    a_act_load: assert property (p_act_load) else $error("set pointer not loaded");
    property p_rsvd;
        @(posedge clk_sys) disable iff (!rst_n)
        base_ff[10:4] == 7'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    // no capability keeps mode bit zero
    property p_edm_cap;
        @(posedge clk_sys) disable iff (!rst_n)
        !caps.extended_dest_capability |=> !base_ff[rmeirq_pkg::EDM_BIT] || $past(base_ff[11]);
    endproperty
    a_edm_cap: assert property (p_edm_cap) else $error("mode bit set without capability");
    // table base reads return zero without remap support
    property p_nosup;
        @(posedge clk_sys) disable iff (!rst_n)
        (setup_rd && !caps.remap_supported && (hit_blo || hit_bhi)) |=> prdata == 32'h0;
    endproperty
    a_nosup: assert property (p_nosup) else $error("unsupported read nonzero");
    // invalid tail captured as code one
    property p_tail;
        @(posedge clk_sys) disable iff (!rst_n)
        (qevt_valid && !queue_error_flag && qevt.tail_bad) |=> detail_ff == 4'h1;
    endproperty
    a_tail: assert property (p_tail) else $error("tail code wrong");
    // misalignment gives code six when nothing higher
    property p_align;
        @(posedge clk_sys) disable iff (!rst_n)
        (qevt_valid && !queue_error_flag && !qevt.tail_bad && !w128_bad && !w256_bad
            && align_bad) |=> detail_ff == 4'h6;
    endproperty
    a_align: assert property (p_align) else $error("align code wrong");
    // code held while the flag is set
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        queue_error_flag |=> $stable(detail_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("detail changed under flag");
    // mode clear keeps only bits 15:8
    property p_dest;
        @(posedge clk_sys) disable iff (!rst_n)
        !act_edm_ff |=> dest_id_used[31:16] == 16'h0 && dest_id_used[7:0] == 8'h0;
    endproperty
    a_dest: assert property (p_dest) else $error("dest bits leaked");
    // bus answers one cycle after setup
    property p_ready;
        @(posedge clk_sys) disable iff (!rst_n)
        (psel && !penable) |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    // detail checks are written from the inputs where they can be, so a slip
    // in the priority chain does not hide behind its own wires
    // capture edge, and no cause ranked above the one under test
    wire cap_edge = qevt_valid && !queue_error_flag;
    wire hi_clear = !qevt.tail_bad && !w128_bad && !w256_bad && !align_bad && !qevt.ttm_bad;
    // mode and size move only on the command
    property p_mode_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !set_ptr |=> $stable(act_edm_ff) && $stable(act_size_ff);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode or size moved");
    // an event with no cause leaves code zero
    property p_none;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && qevt == '0 && translation_table_mode != rmeirq_pkg::TM_SCALABLE)
            |=> detail_ff == rmeirq_pkg::QE_NONE;
    endproperty
    a_none: assert property (p_none) else $error("no-cause code wrong");
    property p_fetch;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && hi_clear && qevt.fetch_err) |=> detail_ff == rmeirq_pkg::QE_FETCH;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch code wrong");
    property p_type;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && hi_clear && !qevt.fetch_err && qevt.type_bad)
            |=> detail_ff == rmeirq_pkg::QE_TYPE;
    endproperty
    a_type: assert property (p_type) else $error("type code wrong");
    property p_rsvd_code;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && hi_clear && !qevt.fetch_err && !qevt.type_bad && qevt.rsvd_bad)
            |=> detail_ff == rmeirq_pkg::QE_RSVD;
    endproperty
    a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code wrong");
    property p_w128;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && !qevt.tail_bad && !qevt.width_256
            && translation_table_mode == rmeirq_pkg::TM_SCALABLE)
            |=> detail_ff == rmeirq_pkg::QE_WIDTH;
    endproperty
    a_w128: assert property (p_w128) else $error("narrow width code wrong");
    property p_w256;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && !qevt.tail_bad && qevt.width_256
            && !caps.scalable_translation_supported && !caps.abort_dma_supported)
            |=> detail_ff == rmeirq_pkg::QE_WIDTH;
    endproperty
    a_w256: assert property (p_w256) else $error("wide width code wrong");
    property p_ttm;
        @(posedge clk_sys) disable iff (!rst_n)
        (cap_edge && !qevt.tail_bad && !w128_bad && !w256_bad && !align_bad
            && qevt.ttm_bad) |=> detail_ff == rmeirq_pkg::QE_TTM;
    endproperty
    a_ttm: assert property (p_ttm) else $error("table mode code wrong");
    // nothing kept at or above host width
    property p_haw;
        @(posedge clk_sys) disable iff (!rst_n)
        (base_ff >> HOST_ADDRESS_WIDTH) == 64'h0 && (act_base_ff >> HOST_ADDRESS_WIDTH) == 64'h0;
    endproperty
    a_haw: assert property (p_haw) else $error("base above host width");
    // mode set passes the full id
    property p_dest_full;
        @(posedge clk_sys) disable iff (!rst_n)
        act_edm_ff |=> dest_id_used == $past(entry_dest_id);
    endproperty
    a_dest_full: assert property (p_dest_full) else $error("full id lost");
    property p_count;
        @(posedge clk_sys) disable iff (!rst_n)
        act_entry_count == (17'h0_0002 << act_size_ff);
    endproperty
    a_count: assert property (p_count) else $error("entry count wrong");
    property p_nosup_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr && !caps.remap_supported) |=> $stable(base_ff);
    endproperty
    a_nosup_wr: assert property (p_nosup_wr) else $error("unsupported write landed");
    property p_rd_rsvd;
        @(posedge clk_sys) disable iff (!rst_n)
        (setup_rd && hit_blo) |=> prdata[10:4] == 7'h00;
    endproperty
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bits read");
    // record word shows the detail code
    property p_rd_rec;
        @(posedge clk_sys) disable iff (!rst_n)
        (setup_rd && hit_elo) |=> prdata == {28'h000_0000, detail_ff};
    endproperty
    a_rd_rec: assert property (p_rd_rec) else $error("record read wrong");
    c_setptr: cover property (@(posedge clk_sys) disable iff (!rst_n) set_ptr);
    c_width: cover property (@(posedge clk_sys) disable iff (!rst_n)
        qevt_valid && (w128_bad || w256_bad));
    c_edm: cover property (@(posedge clk_sys) disable iff (!rst_n) act_edm_ff);
    c_live: cover property (@(posedge clk_sys) disable iff (!rst_n)
        set_ptr && remap_active_status);
endmodule // rmeirq_regs

/* File: test_rmeirq_regs.sv */
// Purpose: self-checking bench for the queue error record and remap table base registers
// Assumes: zero-wait apb slave, one 40 MHz clock, straps changed only while idle
// Notes: assertions live in the design; this bench drives the ports and compares
`timescale 1ns/1ps
module test_rmeirq_regs;
    logic clk_sys; // system clock
    logic rst_n; // async reset, active low
    logic psel, penable, pwrite; // apb request
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr;
    rmeirq_pkg::rmeirq_cap_type caps; // capability straps
    logic [1:0] translation_table_mode;
    rmeirq_pkg::rmeirq_qevt_type qevt; // queue error causes
    logic qevt_valid, queue_error_flag, remap_active_status;
    logic [31:0] entry_dest_id, dest_id_used;
    logic [63:0] act_table_base;
    logic act_extended_dest_mode_enable, set_ptr_done;
    logic [3:0] act_size;
    logic [16:0] act_entry_count;
    int errors, checks_done, done_cnt, base_cnt;
    logic [31:0] rd; // last read data
    logic er; // last slave error
    ////////////////////////////////////////////////////////////////////////////////
    rmeirq_regs #(.HOST_ADDRESS_WIDTH(48)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .caps(caps),
        .translation_table_mode(translation_table_mode), .qevt(qevt),
        .qevt_valid(qevt_valid), .queue_error_flag(queue_error_flag),
        .remap_active_status(remap_active_status), .entry_dest_id(entry_dest_id),
        .act_table_base(act_table_base),
        .act_extended_dest_mode_enable(act_extended_dest_mode_enable),
        .act_size(act_size), .act_entry_count(act_entry_count),
        .dest_id_used(dest_id_used), .set_ptr_done(set_ptr_done));
    // clock generator, 25 ns period
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // count command completions so a lost or doubled pulse shows up
    always @(posedge clk_sys) begin
        if (set_ptr_done === 1'b1) begin
            done_cnt++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // bounded wait: a silent slave must not hang the run
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (n == 16) begin
            errors++;
            $display("MISMATCH at %0t: no pready", $time);
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // issue the set-table-pointer command and expect exactly one completion pulse
    task automatic set_ptr();
        base_cnt = done_cnt;
        apb(1'b1, rmeirq_pkg::CTRL_OFS, 32'h0000_0001);
        repeat (4) @(posedge clk_sys);
        check(done_cnt - base_cnt, 64'h1, "set pointer pulse");
    endtask
    // one queue error event, then the flag rises and the detail code is read
    task automatic err_case(input logic [6:0] ev, input logic [1:0] tm, input logic [3:0] cp,
                            input logic [3:0] code);
        @(posedge clk_sys);
        caps <= cp;
        translation_table_mode <= tm;
        queue_error_flag <= 1'b0;
        @(posedge clk_sys);
        qevt <= ev;
        qevt_valid <= 1'b1;
        @(posedge clk_sys);
        qevt_valid <= 1'b0;
        queue_error_flag <= 1'b1;
        apb(1'b0, rmeirq_pkg::ERR_REC_LO, 32'h0);
        check({er, rd[3:0]}, {1'b0, code}, "detail code");
    endtask
    function automatic logic [16:0] entries(input logic [3:0] s);
        return 17'h1 << (s + 1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        // remap kept inactive while mode is written
        {psel, penable, pwrite, qevt_valid, queue_error_flag, remap_active_status} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        caps = 4'hE;
        translation_table_mode = 2'h0;
        qevt = '0;
        entry_dest_id = 32'h0;
        {errors, checks_done, base_cnt} = '0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset state and refusal of an unmapped place
        check(act_entry_count, 17'h2, "reset entry count");
        apb(1'b0, rmeirq_pkg::TBL_BASE_LO, 32'h0);
        check(rd, 32'h0, "base reset");
        apb(1'b0, 8'hC0, 32'h0);
        check({er, rd}, {1'b1, 32'h0}, "unmapped read");
        $display("test reset done");
        // base, mode and size latch only on the command
        apb(1'b1, rmeirq_pkg::TBL_BASE_LO, 32'hABCD_EFF5);
        apb(1'b1, rmeirq_pkg::TBL_BASE_HI, 32'hFFFF_1234);
        apb(1'b0, rmeirq_pkg::TBL_BASE_LO, 32'h0);
        check(rd, 32'hABCD_E805, "base low readback");
        apb(1'b0, rmeirq_pkg::TBL_BASE_HI, 32'h0);
        check(rd, 32'h0000_1234, "base high readback");
        check(act_table_base, 64'h0, "base held before command");
        check(act_size, 4'h0, "size held before command");
        set_ptr();
        check(act_table_base, 64'h0000_1234_ABCD_E000, "active base");
        check({act_extended_dest_mode_enable, act_size}, 5'h15, "active mode size");
        check(act_entry_count, entries(4'h5), "entry count");
        entry_dest_id <= 32'h1234_5678;
        repeat (3) @(posedge clk_sys);
        check(dest_id_used, 32'h1234_5678, "full destination");
        apb(1'b1, rmeirq_pkg::TBL_BASE_LO, 32'h0000_100F);
        set_ptr();
        check(act_entry_count, entries(4'hF), "largest table");
        repeat (3) @(posedge clk_sys);
        check(dest_id_used, 32'h0000_5600, "narrow destination");
        $display("test table base done");
        // mode bit without capability, register without remap support
        caps <= 4'hA;
        apb(1'b1, rmeirq_pkg::TBL_BASE_LO, 32'h0000_0800);
        apb(1'b0, rmeirq_pkg::TBL_BASE_LO, 32'h0);
        check(rd, 32'h0, "mode bit needs capability");
        caps <= 4'h6;
        apb(1'b1, rmeirq_pkg::TBL_BASE_LO, 32'hFFFF_F003);
        apb(1'b0, rmeirq_pkg::TBL_BASE_LO, 32'h0);
        check(rd, 32'h0, "reads zero unsupported");
        caps <= 4'hE;
        apb(1'b0, rmeirq_pkg::TBL_BASE_LO, 32'h0);
        check(rd, 32'h0, "write was ignored");
        $display("test capability done");
        // every detail code, first cause kept while the flag stands
        err_case(7'h40, 2'h0, 4'hE, rmeirq_pkg::QE_TAIL);
        err_case(7'h20, 2'h0, 4'hE, rmeirq_pkg::QE_FETCH);
        err_case(7'h10, 2'h0, 4'hE, rmeirq_pkg::QE_TYPE);
        err_case(7'h08, 2'h0, 4'hE, rmeirq_pkg::QE_RSVD);
        err_case(7'h00, 2'h1, 4'hE, rmeirq_pkg::QE_WIDTH);
        err_case(7'h04, 2'h0, 4'hC, rmeirq_pkg::QE_WIDTH);
        err_case(7'h06, 2'h0, 4'hE, rmeirq_pkg::QE_ALIGN);
        err_case(7'h00, 2'h0, 4'hE, rmeirq_pkg::QE_NONE);
        err_case(7'h01, 2'h0, 4'hE, rmeirq_pkg::QE_TTM);
        qevt <= 7'h40;
        qevt_valid <= 1'b1;
        @(posedge clk_sys);
        qevt_valid <= 1'b0;
        apb(1'b0, rmeirq_pkg::ERR_REC_LO, 32'h0);
        check(rd[3:0], rmeirq_pkg::QE_TTM, "code kept under flag");
        apb(1'b0, rmeirq_pkg::ERR_REC_HI, 32'h0);
        check({er, rd}, 33'h0, "record high word");
        $display("test detail codes done");
        report_and_stop();
    end
endmodule // test_rmeirq_regs
